/* hws_cfg.svh */
/*
 * Register offsets, reset values and timing figures of the haptic
 * waveform shaping register bank.
 * Assumes a 250 MHz system clock; included by bare name.
 */
`ifndef HWS_CFG_SVH
`define HWS_CFG_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define HWS_OFS_NST 8'h0f
`define HWS_OFS_BRK 8'h10
`define HWS_OFS_RATED 8'h16
`define HWS_OFS_CLAMP 8'h17

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define HWS_RST_NST 8'h00
`define HWS_RST_BRK 8'h00
`define HWS_RST_RATED 8'h3f
`define HWS_RST_CLAMP 8'h89
`define HWS_RD_UNMAPPED 8'h00

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define HWS_STEP_MS 5
`define HWS_CLK_KHZ 250000
`define HWS_STEP_CYC (`HWS_STEP_MS * `HWS_CLK_KHZ)

`endif

/* hws_host_model.sv */
/*
 * Host side model: byte writes and reads on the register port.
 * Assumes callers enter its tasks just after a rising edge of clk.
 */
`timescale 1ns/1ps
`default_nettype none

module hws_host_model (
	// clock
	input wire logic clk,
	// register port
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid
);
	initial
	begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end

	// released lines flip so a stale value never looks valid
	task automatic drop();
		reg_addr = ~reg_addr;
		reg_wdata = ~reg_wdata;
		@(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
		drop();
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output logic v);
		reg_rd = 1'b1;
		reg_addr = a;
		@(posedge clk);
		#1;
		reg_rd = 1'b0;
		d = reg_rdata;
		v = reg_rvalid;
		drop();
	endtask
endmodule

`default_nettype wire

/* hws_pkg.sv */
/*
 * Types shared by the shaping register bank and its segment timer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package hws_pkg;

	// adjusted segment length in 5 ms units, never negative
	typedef logic [8:0] hws_units_t;

	typedef enum logic [1:0] {
		HWS_SEG_OTHER,
		HWS_SEG_NSUS,
		HWS_SEG_BRAKE
	} hws_seg_kind_t;

	typedef enum logic {
		HWS_TMR_IDLE,
		HWS_TMR_RUN
	} hws_tmr_state_t;

endpackage

/* hws_regs.sv */
/*
 * Haptic waveform shaping register bank with segment length shaping,
 * full-scale selection and drive ceiling.
 * Assumes the serial bus front end presents byte accesses on the
 * register port, and all inputs come from logic on clk.
 */
//
// Notes on behaviour
// - negative sustain length shifts by offset*5ms
// - non-overdrive negative samples are negative sustain
// - time offsets are signed two's complement
// - brake length shifts by brake offset*5ms
// - most negative sample level marks braking
// - brake offset only in open loop
// - rated level is closed-loop full scale
// - rated level ignored in open loop
// - clamp register limits automatic overdrive level
// - closed-loop auto periods may exceed rated
// - clamp is open-loop full scale
// - go bit launches calibration when mode selects
`timescale 1ns/1ps
`default_nettype none
`include "hws_cfg.svh"

module hws_regs #(
	parameter int unsigned STEP_CYC = `HWS_STEP_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// waveform segments
	input wire logic closed_loop,
	input wire logic seg_valid,
	input wire logic [7:0] seg_level,
	input wire logic [7:0] wf_min_level,
	input wire logic seg_overdrive,
	input wire logic [7:0] seg_dur,
	output hws_pkg::hws_seg_kind_t seg_kind,
	output logic seg_busy,
	output logic seg_done,
	// drive level
	input wire logic drive_auto,
	input wire logic [7:0] drive_demand,
	output logic [7:0] drive_level,
	output logic [7:0] full_scale,
	// calibration
	input wire logic go_bit,
	input wire logic mode_cal,
	output logic cal_launch,
	output logic cal_stale,
	output logic [7:0] cal_rated_level
);
	import hws_pkg::*;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [7:0] nst_r, nst_nxt, brk_r, brk_nxt;
	logic [7:0] rated_r, rated_nxt, clamp_r, clamp_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic rvalid_r, rvalid_nxt;
	hws_seg_kind_t kind_r, kind_nxt;
	hws_units_t dur_r, dur_nxt;
	logic start_r, start_nxt, busy_r, busy_nxt, done_r, done_nxt;
	logic [7:0] drv_r, drv_nxt, fs_r, fs_nxt;
	logic go_prev_r, launch_r, launch_nxt, stale_r, stale_nxt;
	logic accept, is_neg, is_brake;
	logic [7:0] off, lim;
	logic [9:0] sum;

	hws_seg_if sif();

	hws_seg_timer #(
		.TICK_CYC(STEP_CYC)
	) u_timer (
		.clk(clk),
		.rst(rst),
		.sif(sif)
	);

	assign sif.start = start_r;
	assign sif.dur = dur_r;

	// ---------------------------------------------------------------
	// register file and derived levels
	// ---------------------------------------------------------------
	always_comb
	begin
		nst_nxt = nst_r;
		brk_nxt = brk_r;
		rated_nxt = rated_r;
		clamp_nxt = clamp_r;
		if (reg_wr)
		begin
			unique case (reg_addr)
				`HWS_OFS_NST: nst_nxt = reg_wdata;
				`HWS_OFS_BRK: brk_nxt = reg_wdata;
				`HWS_OFS_RATED: rated_nxt = reg_wdata;
				`HWS_OFS_CLAMP: clamp_nxt = reg_wdata;
				default: ;
			endcase
		end
		rvalid_nxt = reg_rd;
		rdata_nxt = rdata_r;
		if (reg_rd)
		begin
			unique case (reg_addr)
				`HWS_OFS_NST: rdata_nxt = nst_r;
				`HWS_OFS_BRK: rdata_nxt = brk_r;
				`HWS_OFS_RATED: rdata_nxt = rated_r;
				`HWS_OFS_CLAMP: rdata_nxt = clamp_r;
				default: rdata_nxt = `HWS_RD_UNMAPPED;
			endcase
		end
		// open loop takes the clamp as full scale, rated is unused there
		fs_nxt = closed_loop ? rated_r : clamp_r;
		// auto overdrive and braking may pass rated, never the clamp
		if (closed_loop && !drive_auto)
			lim = rated_r;
		else
			lim = clamp_r;
		drv_nxt = (drive_demand > lim) ? lim : drive_demand;
		launch_nxt = go_bit && !go_prev_r && mode_cal;
		// a rated write in the launch cycle keeps the flag set
		stale_nxt = stale_r;
		if (launch_nxt)
			stale_nxt = 1'b0;
		if (reg_wr && reg_addr == `HWS_OFS_RATED)
			stale_nxt = 1'b1;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			nst_r <= `HWS_RST_NST;
			brk_r <= `HWS_RST_BRK;
			rated_r <= `HWS_RST_RATED;
			clamp_r <= `HWS_RST_CLAMP;
			rdata_r <= `HWS_RD_UNMAPPED;
			rvalid_r <= 1'b0;
			fs_r <= `HWS_RST_RATED;
			drv_r <= 8'h00;
			go_prev_r <= 1'b0;
			launch_r <= 1'b0;
			stale_r <= 1'b0;
		end
		else
		begin
			nst_r <= nst_nxt;
			brk_r <= brk_nxt;
			rated_r <= rated_nxt;
			clamp_r <= clamp_nxt;
			rdata_r <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
			fs_r <= fs_nxt;
			drv_r <= drv_nxt;
			go_prev_r <= go_bit;
			launch_r <= launch_nxt;
			stale_r <= stale_nxt;
		end
	end

	// ---------------------------------------------------------------
	// segment classification and length shaping
	// ---------------------------------------------------------------
	always_comb
	begin
		accept = seg_valid && !busy_r;
		is_neg = seg_level[7] && !seg_overdrive;
		is_brake = is_neg && (seg_level == wf_min_level);
		kind_nxt = kind_r;
		dur_nxt = dur_r;
		start_nxt = 1'b0;
		off = 8'h00;
		if (is_brake)
			off = closed_loop ? 8'h00 : brk_r;
		else if (is_neg)
			off = nst_r;
		// sign extension lets the offset remove time as well
		sum = {2'b00, seg_dur} + {{2{off[7]}}, off};
		if (accept)
		begin
			start_nxt = 1'b1;
			if (is_brake)
				kind_nxt = HWS_SEG_BRAKE;
			else if (is_neg)
				kind_nxt = HWS_SEG_NSUS;
			else
				kind_nxt = HWS_SEG_OTHER;
			dur_nxt = sum[9] ? 9'h000 : sum[8:0];
		end
		busy_nxt = busy_r;
		if (accept)
			busy_nxt = 1'b1;
		else if (sif.done)
			busy_nxt = 1'b0;
		done_nxt = sif.done;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			kind_r <= HWS_SEG_OTHER;
			dur_r <= 9'h000;
			start_r <= 1'b0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end
		else
		begin
			kind_r <= kind_nxt;
			dur_r <= dur_nxt;
			start_r <= start_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
		end
	end

	assign reg_rdata = rdata_r;
	assign reg_rvalid = rvalid_r;
	assign seg_kind = kind_r;
	assign seg_busy = busy_r;
	assign seg_done = done_r;
	assign drive_level = drv_r;
	assign full_scale = fs_r;
	assign cal_launch = launch_r;
	assign cal_stale = stale_r;
	assign cal_rated_level = rated_r;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_go_rise;
		!go_bit ##1 (go_bit && mode_cal);
	endsequence

	sequence s_seg_take;
		seg_valid && !busy_r;
	endsequence

	a_closed_fullscale: assert property (closed_loop |=>
		fs_r == $past(rated_r))
		else $error("closed loop full scale is not the rated level");
	a_open_fullscale: assert property (!closed_loop |=>
		fs_r == $past(clamp_r))
		else $error("open loop full scale is not the clamp level");
	a_auto_ceiling: assert property ((drive_auto || !closed_loop) |=>
		drv_r <= $past(clamp_r))
		else $error("drive level above the clamp");
	a_rated_ceiling: assert property ((closed_loop && !drive_auto) |=>
		drv_r <= $past(rated_r))
		else $error("steady closed loop drive above rated level");
	a_go_launch: assert property (s_go_rise |=> launch_r ##1 !launch_r)
		else $error("go rise did not launch calibration once");
	a_brake_open: assert property ((s_seg_take and is_brake && !closed_loop
		&& !sum[9]) |=> start_r && kind_r == HWS_SEG_BRAKE
		&& dur_r == 9'($past(seg_dur)) + 9'({{1{$past(brk_r[7])}}, $past(brk_r)}))
		else $error("brake offset not applied in open loop");
	a_brake_closed: assert property ((s_seg_take and is_brake && closed_loop)
		|=> dur_r == {1'b0, $past(seg_dur)})
		else $error("brake offset applied in closed loop");
	a_nsus_kind: assert property ((s_seg_take and is_neg && !is_brake)
		|=> kind_r == HWS_SEG_NSUS ##1 busy_r)
		else $error("negative sample not treated as sustain");
	a_sat_zero: assert property ((s_seg_take and sum[9]) |=> dur_r == 9'h000)
		else $error("negative adjusted length did not saturate");
	a_stale_set: assert property ((reg_wr && reg_addr == `HWS_OFS_RATED)
		|=> stale_r)
		else $error("rated write did not flag calibration stale");

endmodule

`default_nettype wire

/* hws_regs_test.sv */
/*
 * Self-checking bench for the shaping register bank.
 * Assumes the host model owns the register port.
 */
`timescale 1ns/1ps
`default_nettype none

module hws_regs_test;
	import hws_pkg::*;
	typedef struct {logic [7:0] a; logic [7:0] r; logic [7:0] w;} hws_row_t;
	localparam int unsigned STEP = 2;
	logic clk = 0, rst = 1, reg_wr, reg_rd, reg_rvalid, v;
	logic closed_loop = 0, seg_valid = 0, seg_overdrive = 0;
	logic seg_busy, seg_done, drive_auto = 0, go_bit = 0, mode_cal = 0;
	logic cal_launch, cal_stale;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d, seg_level = 0;
	logic [7:0] wf_min_level = 8'h80, seg_dur = 0, drive_demand = 0;
	logic [7:0] drive_level, full_scale, cal_rated_level;
	hws_seg_kind_t seg_kind;
	int err_count = 0, checked = 0, b, l, n;
	// address, reset value, value written; 0x20 is unmapped
	hws_row_t rows [5] = '{'{8'h0f, 8'h00, 8'hff},
		'{8'h10, 8'h00, 8'h02}, '{8'h16, 8'h3f, 8'h50},
		'{8'h17, 8'h89, 8'h70}, '{8'h20, 8'h00, 8'h55}};

	hws_regs #(.STEP_CYC(STEP)) hws_regs_i (.clk, .rst, .reg_wr, .reg_rd,
		.reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .closed_loop,
		.seg_valid, .seg_level, .wf_min_level, .seg_overdrive, .seg_dur,
		.seg_kind, .seg_busy, .seg_done, .drive_auto, .drive_demand,
		.drive_level, .full_scale, .go_bit, .mode_cal, .cal_launch,
		.cal_stale, .cal_rated_level);
	hws_host_model hws_host_model_i (.clk, .reg_wr, .reg_rd, .reg_addr,
		.reg_wdata, .reg_rdata, .reg_rvalid);

	always #2 clk = ~clk;

	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e)
		begin
			err_count++;
			$display("mismatch at %0t seen %h exp %h", $time, s, e);
		end
	endtask

	task automatic results();
		$display("checked %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	// latency counted from the take edge; only differences are compared
	task automatic seg(input logic [7:0] lv, input logic od,
		input logic [7:0] du, input hws_seg_kind_t k, output int lat);
		seg_level = lv;
		seg_overdrive = od;
		seg_dur = du;
		seg_valid = 1'b1;
		cyc(1);
		seg_valid = 1'b0;
		lat = 1;
		while (seg_done !== 1'b1 && lat < 100)
		begin
			cyc(1);
			lat++;
		end
		if (lat >= 100)
		begin
			err_count++;
			results();
		end
		chk(8'(seg_kind), 8'(k));
		cyc(2);
	endtask

	task automatic drv(input logic cl, input logic au, input logic [7:0] dm,
		input logic [7:0] el, input logic [7:0] ef);
		closed_loop = cl;
		drive_auto = au;
		drive_demand = dm;
		cyc(2);
		chk(drive_level, el);
		chk(full_scale, ef);
	endtask

	initial
	begin
		cyc(10);
		rst = 1'b0;
		foreach (rows[i])
		begin
			hws_host_model_i.rd(rows[i].a, d, v);
			chk(d, rows[i].r);
			chk(8'(v), 8'h01);
		end
		foreach (rows[i])
		begin
			hws_host_model_i.wr(rows[i].a, rows[i].w);
			hws_host_model_i.rd(rows[i].a, d, v);
			chk(d, rows[i].a == 8'h20 ? 8'h00 : rows[i].w);
		end
		$display("test registers done");
		chk(8'(cal_stale), 8'h01);
		chk(cal_rated_level, 8'h50);
		mode_cal = 1'b1;
		go_bit = 1'b1;
		n = 0;
		repeat (4)
		begin
			cyc(1);
			n += int'(cal_launch === 1'b1);
		end
		chk(8'(n), 8'h01);
		chk(8'(cal_stale), 8'h00);
		go_bit = 1'b0;
		$display("test calibration done");
		seg(8'h10, 1'b0, 8'h01, HWS_SEG_OTHER, b);
		seg(8'hf0, 1'b0, 8'h03, HWS_SEG_NSUS, l);
		chk(8'(l - b), 8'(STEP));
		seg(8'h80, 1'b0, 8'h01, HWS_SEG_BRAKE, l);
		chk(8'(l - b), 8'(2 * STEP));
		seg(8'hf0, 1'b1, 8'h01, HWS_SEG_OTHER, l);
		chk(8'(l - b), 8'h00);
		seg(8'hf0, 1'b0, 8'h00, HWS_SEG_NSUS, l);
		chk(8'(l < b), 8'h01);
		closed_loop = 1'b1;
		seg(8'h80, 1'b0, 8'h01, HWS_SEG_BRAKE, l);
		chk(8'(l - b), 8'h00);
		$display("test segments done");
		drv(1'b1, 1'b1, 8'hff, 8'h70, 8'h50);
		drv(1'b1, 1'b1, 8'h60, 8'h60, 8'h50);
		drv(1'b1, 1'b0, 8'hff, 8'h50, 8'h50);
		drv(1'b0, 1'b0, 8'hff, 8'h70, 8'h70);
		$display("test drive done");
		rst = 1'b1;
		cyc(2);
		chk(8'(seg_busy), 8'h00);
		chk(full_scale, 8'h3f);
		chk(drive_level, 8'h00);
		chk(cal_rated_level, 8'h3f);
		chk(8'(cal_stale), 8'h00);
		rst = 1'b0;
		hws_host_model_i.rd(8'h17, d, v);
		chk(d, 8'h89);
		hws_host_model_i.rd(8'h16, d, v);
		chk(d, 8'h3f);
		chk(8'(reg_rvalid), 8'h00);
		$display("test reset done");
		results();
	end
endmodule

`default_nettype wire

/* hws_seg_if.sv */
/*
 * Carrier between the register bank and the segment timer.
 * Assumes both ends share the system clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface hws_seg_if;
	logic start;
	hws_pkg::hws_units_t dur;
	logic busy;
	logic done;

	modport ctl (output start, output dur, input busy, input done);
	modport tmr (input start, input dur, output busy, output done);
endinterface

`default_nettype wire

/* hws_seg_timer.sv */
/*
 * Segment timer: counts out an adjusted segment length in 5 ms units.
 * Assumes start is a one-cycle pulse raised only while idle.
 */
`timescale 1ns/1ps
`default_nettype none
`include "hws_cfg.svh"

module hws_seg_timer #(
	parameter int unsigned TICK_CYC = `HWS_STEP_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// segment handshake
	hws_seg_if.tmr sif
);
	import hws_pkg::*;

	hws_tmr_state_t state_r, state_nxt;
	hws_units_t units_r, units_nxt;
	logic [31:0] tick_r, tick_nxt;
	logic done_r, done_nxt;

	always_comb
	begin
		state_nxt = state_r;
		units_nxt = units_r;
		tick_nxt = tick_r;
		done_nxt = 1'b0;
		unique case (state_r)
			HWS_TMR_IDLE:
			begin
				if (sif.start)
				begin
					// zero length finishes at once instead of wrapping
					if (sif.dur == 9'h000)
						done_nxt = 1'b1;
					else
					begin
						state_nxt = HWS_TMR_RUN;
						units_nxt = sif.dur;
						tick_nxt = 32'h0000_0000;
					end
				end
			end
			HWS_TMR_RUN:
			begin
				if (tick_r == 32'(TICK_CYC - 1))
				begin
					tick_nxt = 32'h0000_0000;
					units_nxt = units_r - 9'h001;
					if (units_r == 9'h001)
					begin
						state_nxt = HWS_TMR_IDLE;
						done_nxt = 1'b1;
					end
				end
				else
					tick_nxt = tick_r + 32'h0000_0001;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_r <= HWS_TMR_IDLE;
			units_r <= 9'h000;
			tick_r <= 32'h0000_0000;
			done_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			units_r <= units_nxt;
			tick_r <= tick_nxt;
			done_r <= done_nxt;
		end
	end

	assign sif.busy = (state_r == HWS_TMR_RUN);
	assign sif.done = done_r;

	a_zero_done: assert property (@(posedge clk) disable iff (rst)
		(sif.start && !sif.busy && sif.dur == 9'h000) |=> done_r)
		else $error("zero length segment did not finish at once");

endmodule

`default_nettype wire
